/* rtl/tmc_top.sv */
// mode configuration, host pin role decode and port setup of the tdm-over-packet device
`timescale 1ns/10ps
`include "tmc_consts.svh"

// Functional notes
// R01: high-speed bit commits device to one stream
// R02: high-speed carries unstructured aal1 or satop only
// R03: each low-speed port picks e1, t1, serial
// R04: e1/t1 ports pick unframed, framed, multiframed
// R05: per port one-clock or two-clock timing
// R06: one configuration register per port
// R07: bus strap 1 parallel, 0 serial
// R08: width strap 1 32-bit, 0 16-bit
// R09: serial: rw pin phase, lane0 clock
// R10: serial: lane1 data in, d0 data out
// R11: only asserted byte lanes are written
// R12: core clock rate given by select input
// R13: identity and revision readable by software
// R14: multiframe pin is sync in or carrier
// R15: signaling pins or cts and rts
// R16: serial: lane2 pin is chip select
// R17: serial: lane3 pin inverts clock polarity
// R18: parallel: ready output low when access done
// R19: serial ports carrier/cts/rts, e1/t1 sync/signaling
// R20: software reset equals hardware reset for config
module tmc_top #(
    parameter logic [15:0] DEVICE_ID = 16'h0a5c, // arbitrary value
    parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
    input wire logic clk, // core clock, 50 mhz
    input wire logic rst_n, // async reset, active low
    input tmc_pkg::tmc_reg_req_t reg_req, // register request
    output logic [31:0] reg_rdata, // read data, cycle after read
    input wire logic host_bus_strap, // 1 parallel, 0 serial
    input wire logic host_width_strap, // 1 32-bit, 0 16-bit
    input wire logic [1:0] core_clock_rate_select, // 25/50/75 mhz
    input wire logic read_write_or_serial_phase, // rw or phase
    input wire logic lane0_write_or_serial_clock, // be0_n or clock
    input wire logic lane1_write_or_serial_in, // be1_n or data in
    input wire logic lane2_write_or_serial_select, // be2_n or select_n
    input wire logic lane3_write_or_clock_invert, // be3_n or invert
    input wire logic serial_dout, // serial engine output bit
    output logic host_d0_o, // host data bit 0 drive value
    output logic host_d0_oe, // host data bit 0 drive enable
    output logic host_ready_n_o, // ready, active low
    output logic host_ready_oe, // ready drive enable
    output tmc_pkg::tmc_host_role_t host_role_o, // decoded pin roles
    output logic [3:0] par_be_n_o, // parallel byte write enables
    output logic [1:0] clk_rate_o, // captured core clock rate
    output logic high_speed_o, // high-speed mode
    output logic payload_o, // 0 aal1, 1 satop in high-speed
    output logic [7:0] port_active_o, // ports in service
    output tmc_pkg::tmc_port_cfg_t [7:0] port_cfg_o, // effective port setup
    input wire logic [7:0] line_tx_sig, // core signaling per port
    input wire logic [7:0] line_tx_multiframe_or_carrier_i, // pin in
    output logic [7:0] line_tx_multiframe_or_carrier_o, // pin out
    output logic [7:0] line_tx_multiframe_or_carrier_oe, // pin enable
    output logic [7:0] line_tx_signaling_or_clear_to_send, // pin out
    input wire logic [7:0] line_rx_signaling_or_request_to_send, // pin in
    output logic [7:0] line_rx_sig_o, // rx signaling to core
    output logic [7:0] line_rts_o, // request to send to core
    output logic [7:0] line_mf_sync_o, // multiframe sync to core
    output logic [7:0] line_rx_clk_sel_o // 1 own rx clock
);

    // ------------
    // declarations
    // ------------
    logic [8:0] host_pins; // raw host-side pins
    logic [8:0] host_lvl; // synced host-side pins
    logic [15:0] line_lvl; // synced line pins
    tmc_pkg::tmc_strap_st_t st_q, st_d; // strap capture state
    logic [2:0] cnt_q, cnt_d; // settle counter
    logic ser_q, ser_d; // captured serial host bus
    logic w32_q, w32_d; // captured 32-bit width
    logic [1:0] rate_q, rate_d; // captured clock rate
    logic hs_q, hs_d; // high-speed bit
    logic pay_q, pay_d; // payload type bit
    logic srst_q, srst_d; // soft reset pulse
    logic live; // straps captured, requests taken
    logic acc_wr, acc_rd; // accepted strobes
    logic [3:0] lanes; // effective byte lanes
    logic [31:0] rdata_q, rdata_d; // read data register
    logic rdy_n_q, rdy_n_d; // ready value
    logic rdy_oe_q, rdy_oe_d; // ready enable
    tmc_pkg::tmc_host_role_t role_q, role_d; // host pin roles
    logic [3:0] be_q, be_d; // parallel write enables
    logic d0_q, d0_d; // data bit 0 value
    logic d0_oe_q, d0_oe_d; // data bit 0 enable
    logic [7:0] act_q, act_d; // active ports
    logic [7:0] port_wr; // per-port write strobe
    tmc_pkg::tmc_port_cfg_t [7:0] cfg_raw; // stored port words

    assign host_pins = {host_bus_strap, host_width_strap, core_clock_rate_select,
                        read_write_or_serial_phase, lane0_write_or_serial_clock,
                        lane1_write_or_serial_in, lane2_write_or_serial_select,
                        lane3_write_or_clock_invert};

    // ------------
    // pin synchronisers
    // ------------
    tmc_sync #(.W(9)) u_host_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(host_pins),
        .level(host_lvl)
    );

    tmc_sync #(.W(16)) u_line_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin({line_rx_signaling_or_request_to_send, line_tx_multiframe_or_carrier_i}),
        .level(line_lvl)
    );

    // ------------
    // strap capture
    // ------------
    // straps are caught once, at the fifth edge: the filter holds zero through the third
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ser_d = ser_q;
        w32_d = w32_q;
        rate_d = rate_q;
        case (st_q)
            tmc_pkg::TMC_ST_SETTLE: begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == `TMC_STRAP_SETTLE) begin
                    ser_d = ~host_lvl[8]; // see R07
                    w32_d = host_lvl[7]; // see R08
                    rate_d = host_lvl[6:5]; // see R12
                    st_d = tmc_pkg::TMC_ST_LIVE;
                end
            end
            tmc_pkg::TMC_ST_LIVE: begin
                st_d = tmc_pkg::TMC_ST_LIVE;
            end
            default: begin
                st_d = tmc_pkg::TMC_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= tmc_pkg::TMC_ST_SETTLE;
            cnt_q <= 3'h0;
            ser_q <= 1'b0;
            w32_q <= 1'b0;
            rate_q <= 2'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ser_q <= ser_d;
            w32_q <= w32_d;
            rate_q <= rate_d;
        end
    end

    assign live = (st_q == tmc_pkg::TMC_ST_LIVE);
    assign acc_wr = live && reg_req.wr;
    assign acc_rd = live && reg_req.rd;
    // a 16-bit bus has no upper lanes, so those can never be written
    assign lanes = ~reg_req.be_n & (w32_q ? `TMC_LANES_W32 : `TMC_LANES_W16); // see R08

    // ------------
    // global config word
    // ------------
    always_comb begin
        hs_d = hs_q;
        pay_d = pay_q;
        srst_d = 1'b0;
        if (srst_q) begin
            hs_d = 1'b0; // see R20
            pay_d = 1'b0;
        end else if (acc_wr && reg_req.addr == `TMC_OFS_GLOBAL) begin
            if (lanes[0]) begin
                hs_d = reg_req.wdata[`TMC_GLB_HS_BIT]; // see R01
                pay_d = reg_req.wdata[`TMC_GLB_PAY_BIT]; // see R02
            end
            if (lanes[1]) begin
                srst_d = reg_req.wdata[`TMC_GLB_SRST_BIT]; // see R11
            end
        end
        // high-speed keeps port 0 alone in service
        act_d = hs_q ? 8'h01 : 8'hff; // see R01
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_q <= 1'b0;
            pay_q <= 1'b0;
            srst_q <= 1'b0;
            act_q <= 8'hff;
        end else begin
            hs_q <= hs_d;
            pay_q <= pay_d;
            srst_q <= srst_d;
            act_q <= act_d;
        end
    end

    // ------------
    // ports
    // ------------
    // writes take lane 0 only, the port word is six bits wide
    genvar g;
    generate
        for (g = 0; g < `TMC_NUM_PORTS; g++) begin : g_port
            assign port_wr[g] = acc_wr && lanes[0] &&
                (reg_req.addr == `TMC_OFS_PORT0 + 6'(g) * `TMC_PORT_STRIDE); // see R06
            tmc_port u_port (
                .clk(clk),
                .rst_n(rst_n),
                .wr_en(port_wr[g]),
                .wdata(reg_req.wdata[5:0]),
                .soft_rst(srst_q),
                .hs(hs_q),
                .mf_in(line_lvl[g]),
                .rts_in(line_lvl[8+g]),
                .sig_tx(line_tx_sig[g]),
                .cfg(cfg_raw[g]),
                .eff(port_cfg_o[g]),
                .mf_cd_o(line_tx_multiframe_or_carrier_o[g]),
                .mf_cd_oe(line_tx_multiframe_or_carrier_oe[g]),
                .tsig_cts_o(line_tx_signaling_or_clear_to_send[g]),
                .rx_sig_o(line_rx_sig_o[g]),
                .rts_o(line_rts_o[g]),
                .mf_sync_o(line_mf_sync_o[g]),
                .rx_clk_sel_o(line_rx_clk_sel_o[g])
            );
        end
    endgenerate

    // ------------
    // read data
    // ------------
    // unmapped offsets read as zero, data stand for one cycle only
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (acc_rd) begin
            if (reg_req.addr == `TMC_OFS_GLOBAL) begin
                rdata_d[`TMC_GLB_HS_BIT] = hs_q;
                rdata_d[`TMC_GLB_PAY_BIT] = pay_q;
            end else if (reg_req.addr == `TMC_OFS_IDENT) begin
                rdata_d = {DEVICE_ID, 8'h00, REVISION}; // see R13
            end else if (reg_req.addr == `TMC_OFS_STATUS) begin
                rdata_d[`TMC_STS_SERIAL_BIT] = ser_q;
                rdata_d[`TMC_STS_W32_BIT] = w32_q;
                rdata_d[`TMC_STS_HS_BIT] = hs_q;
                rdata_d[`TMC_STS_RATE_LSB +: 2] = rate_q; // see R12
            end else begin
                for (int i = 0; i < `TMC_NUM_PORTS; i++) begin
                    if (reg_req.addr == `TMC_OFS_PORT0 + 6'(i) * `TMC_PORT_STRIDE) begin
                        rdata_d[5:0] = cfg_raw[i];
                    end
                end
            end
        end
    end

    // ------------
    // host pin roles and ready
    // ------------
    always_comb begin
        role_d.serial = ser_q;
        role_d.width32 = w32_q;
        role_d.cpha = ser_q & host_lvl[4]; // see R09
        role_d.sclk = ser_q & host_lvl[3]; // see R09
        role_d.sdi = ser_q & host_lvl[2]; // see R10
        role_d.sel_n = ~ser_q | host_lvl[1]; // see R16
        role_d.cpol = ser_q & host_lvl[0]; // see R17
        // lane n pin is write enable n; none in serial mode or before capture
        be_d = (!live || ser_q) ? 4'hf : {host_lvl[0], host_lvl[1], host_lvl[2], host_lvl[3]} |
            ~(w32_q ? `TMC_LANES_W32 : `TMC_LANES_W16); // see R11
        d0_oe_d = live && ser_q && !host_lvl[1]; // see R10
        d0_d = serial_dout;
        // ready low and driven in the cycle the access completes
        rdy_n_d = !(live && !ser_q && (acc_wr || acc_rd)); // see R18
        rdy_oe_d = !rdy_n_d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            role_q <= '0;
            be_q <= 4'hf;
            d0_q <= 1'b0;
            d0_oe_q <= 1'b0;
            rdy_n_q <= 1'b1;
            rdy_oe_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            role_q <= role_d;
            be_q <= be_d;
            d0_q <= d0_d;
            d0_oe_q <= d0_oe_d;
            rdy_n_q <= rdy_n_d;
            rdy_oe_q <= rdy_oe_d;
        end
    end

    // ------------
    // outputs
    // ------------
    assign reg_rdata = rdata_q;
    assign host_role_o = role_q;
    assign par_be_n_o = be_q; // see R11
    assign host_d0_o = d0_q;
    assign host_d0_oe = d0_oe_q;
    assign host_ready_n_o = rdy_n_q;
    assign host_ready_oe = rdy_oe_q;
    assign clk_rate_o = rate_q;
    assign high_speed_o = hs_q;
    assign payload_o = pay_q;
    assign port_active_o = act_q;

endmodule // tmc_top

/* rtl/tmc_consts.svh */
// offsets, field positions, reset values and counts of the mode configuration block
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ------------
// register offsets (byte addresses)
// ------------
`define TMC_OFS_GLOBAL 6'h00
`define TMC_OFS_IDENT 6'h04
`define TMC_OFS_STATUS 6'h08
`define TMC_OFS_PORT0 6'h20
`define TMC_PORT_STRIDE 6'h04

// ------------
// global config word fields
// ------------
`define TMC_GLB_HS_BIT 0
`define TMC_GLB_PAY_BIT 1
`define TMC_GLB_SRST_BIT 8

// ------------
// status word fields
// ------------
`define TMC_STS_SERIAL_BIT 0
`define TMC_STS_W32_BIT 1
`define TMC_STS_HS_BIT 2
`define TMC_STS_RATE_LSB 4

// ------------
// sizes, reset values and counts
// ------------
`define TMC_NUM_PORTS 8
`define TMC_PORT_CFG_W 6
`define TMC_PORT_RESET 6'h00
`define TMC_LANES_W32 4'hf
`define TMC_LANES_W16 4'h3
`define TMC_STRAP_SETTLE 3'h4

`endif

/* rtl/tmc_pkg.sv */
// types shared by the mode configuration block
package tmc_pkg;

    // line type of one low-speed port
    typedef enum logic [1:0] {
        TMC_LINE_E1 = 2'b00,
        TMC_LINE_T1 = 2'b01,
        TMC_LINE_SERIAL = 2'b10
    } tmc_line_t;

    // framing format of an e1/t1 port
    typedef enum logic [1:0] {
        TMC_FRM_UNFRAMED = 2'b00,
        TMC_FRM_FRAMED = 2'b01,
        TMC_FRM_MULTI = 2'b10
    } tmc_frame_t;

    // strap capture state
    typedef enum logic [1:0] {
        TMC_ST_SETTLE = 2'b00,
        TMC_ST_LIVE = 2'b01
    } tmc_strap_st_t;

    // per-port configuration word, bit 5 down to bit 0
    typedef struct packed {
        logic carrier;
        logic two_clk;
        tmc_frame_t framing;
        tmc_line_t line;
    } tmc_port_cfg_t;

    // register port request
    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic [3:0] be_n;
        logic wr;
        logic rd;
    } tmc_reg_req_t;

    // decoded roles of the shared host pins
    typedef struct packed {
        logic serial;
        logic width32;
        logic cpha;
        logic cpol;
        logic sclk;
        logic sdi;
        logic sel_n;
    } tmc_host_role_t;

endpackage : tmc_pkg

/* rtl/tmc_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps

module tmc_sync #(
    parameter int W = 1
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] pin, // raw pin levels
    output logic [W-1:0] level // filtered level
);

    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [W-1:0] lvl_d;

    // ------------
    // agreement filter
    // ------------
    // a change counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    end

    // stage one is read only by stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;

endmodule // tmc_sync

/* rtl/tmc_port.sv */
// one tdm port: its configuration register and the role of its dual-use pins
`timescale 1ns/10ps
`include "tmc_consts.svh"

module tmc_port (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic wr_en, // write this port's register
    input wire logic [5:0] wdata, // new register value
    input wire logic soft_rst, // software reset pulse
    input wire logic hs, // high-speed mode, port carries one stream
    input wire logic mf_in, // synced multiframe sync pin
    input wire logic rts_in, // synced rx signaling pin
    input wire logic sig_tx, // signaling bit from the core
    output tmc_pkg::tmc_port_cfg_t cfg, // stored register
    output tmc_pkg::tmc_port_cfg_t eff, // effective setting
    output logic mf_cd_o, // multiframe pin drive value
    output logic mf_cd_oe, // multiframe pin drive enable
    output logic tsig_cts_o, // tx signaling or clear to send
    output logic rx_sig_o, // rx signaling to the core
    output logic rts_o, // request to send to the core
    output logic mf_sync_o, // multiframe sync to the core
    output logic rx_clk_sel_o // 1 = rx runs on its own clock
);

    tmc_pkg::tmc_port_cfg_t cfg_q, cfg_d, eff_d, eff_q;
    logic [5:0] pin_d, pin_q; // registered pin roles
    logic ser; // port runs as serial line

    // ------------
    // next values
    // ------------
    always_comb begin
        cfg_d = cfg_q;
        if (soft_rst) begin
            cfg_d = tmc_pkg::tmc_port_cfg_t'(`TMC_PORT_RESET); // see R20
        end else if (wr_en) begin
            cfg_d = tmc_pkg::tmc_port_cfg_t'(wdata); // see R06
        end
        eff_d = cfg_q; // see R03
        ser = (cfg_q.line == tmc_pkg::TMC_LINE_SERIAL);
        // framing only means something on e1/t1 and high-speed is unstructured
        if (ser || hs) begin
            eff_d.framing = tmc_pkg::TMC_FRM_UNFRAMED; // see R04
        end
        if (hs) begin
            eff_d.line = tmc_pkg::TMC_LINE_E1;
        end
        // serial lines use carrier, cts and rts; e1/t1 use sync and signaling
        pin_d[0] = ser ? cfg_q.carrier : 1'b0; // see R14
        pin_d[1] = ser; // see R19
        pin_d[2] = ser ? rts_in : sig_tx; // see R15
        pin_d[3] = ser ? 1'b0 : rts_in;
        pin_d[4] = ser ? rts_in : 1'b0;
        pin_d[5] = ser ? 1'b0 : mf_in;
    end

    // ------------
    // registers
    // ------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= tmc_pkg::tmc_port_cfg_t'(`TMC_PORT_RESET);
            eff_q <= tmc_pkg::tmc_port_cfg_t'(`TMC_PORT_RESET);
            pin_q <= 6'h00;
        end else begin
            cfg_q <= cfg_d;
            eff_q <= eff_d;
            pin_q <= pin_d;
        end
    end

    assign cfg = cfg_q;
    assign eff = eff_q;
    assign mf_cd_o = pin_q[0];
    assign mf_cd_oe = pin_q[1];
    assign tsig_cts_o = pin_q[2];
    assign rx_sig_o = pin_q[3];
    assign rts_o = pin_q[4];
    assign mf_sync_o = pin_q[5];
    assign rx_clk_sel_o = eff_q.two_clk; // see R05

endmodule // tmc_port

/* verification/tmc_top_asserts.sv */
// port assertions of the mode configuration block and their bind
`timescale 1ns/10ps

module tmc_chk (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input tmc_pkg::tmc_reg_req_t reg_req, // register request
    input wire logic [31:0] reg_rdata, // read data
    input wire logic host_ready_n_o, // ready, active low
    input wire logic host_ready_oe, // ready drive enable
    input tmc_pkg::tmc_host_role_t host_role_o, // decoded pin roles
    input wire logic host_d0_oe, // data bit 0 enable
    input wire logic [3:0] par_be_n_o, // lane write enables
    input wire logic high_speed_o, // high-speed mode
    input wire logic [7:0] port_active_o, // ports in service
    input tmc_pkg::tmc_port_cfg_t [7:0] port_cfg_o, // effective setup
    input wire logic [7:0] line_rts_o, // request to send
    input wire logic [7:0] line_rx_sig_o // rx signaling
);
    // ------------
    // one clock domain, so one default clocking
    // ------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RDY_OE: assert property (!host_ready_n_o |-> host_ready_oe)
        else $error("ready low while undriven");
    AST_RDY_PULSE: assert property (!(reg_req.rd | reg_req.wr) |=> host_ready_n_o)
        else $error("ready held after access");
    AST_RDY_CAUSE: assert property ($fell(host_ready_n_o) |-> $past(reg_req.rd | reg_req.wr))
        else $error("ready without access");
    AST_RDATA_IDLE: assert property (!reg_req.rd |=> reg_rdata == 32'h0)
        else $error("read data without read");
    AST_HS_PORTS: assert property ($rose(high_speed_o) |-> ##[0:1] port_active_o == 8'h01)
        else $error("high speed left several ports");
    AST_HS_UNSTR: assert property (high_speed_o && $past(high_speed_o)
        |-> port_cfg_o[0].framing == tmc_pkg::TMC_FRM_UNFRAMED)
        else $error("structured framing in high speed");
    AST_SER_QUIET: assert property (host_role_o.serial && $past(host_role_o.serial)
        |-> host_ready_n_o && par_be_n_o == 4'hf)
        else $error("parallel signals in serial mode");
    AST_W16_LANES: assert property (!host_role_o.width32 |-> par_be_n_o[3:2] == 2'b11)
        else $error("upper lanes live in narrow mode");
    AST_D0_SERIAL: assert property (host_d0_oe |-> host_role_o.serial)
        else $error("data bit 0 driven outside serial");
    AST_SIG_EXCL: assert property ((line_rts_o & line_rx_sig_o) == 8'h0)
        else $error("port gives both rts and signaling");
endmodule // tmc_chk

bind tmc_top tmc_chk i_tmc_chk (.clk, .rst_n, .reg_req, .reg_rdata, .host_ready_n_o,
    .host_ready_oe, .host_role_o, .host_d0_oe, .par_be_n_o, .high_speed_o, .port_active_o,
    .port_cfg_o, .line_rts_o, .line_rx_sig_o);

/* verification/tmc_host.sv */
// host processor model on the register port
`timescale 1ns/10ps

module tmc_host (
    input wire logic clk, // core clock
    input wire logic [31:0] reg_rdata, // read data
    input wire logic host_ready_n_o, // ready, active low
    output tmc_pkg::tmc_reg_req_t reg_req // request to the block
);
    // ------------
    // bus cycles
    // ------------
    initial reg_req = '0;

    // one-cycle write; lanes enabled by low bits
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be_n);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, be_n: be_n, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask

    // one-cycle read; data and ready stand only in the cycle after
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic rdy_n);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0, be_n: 4'hf, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
        rdy_n = host_ready_n_o;
    endtask
endmodule // tmc_host

/* verification/tmc_top_tb_top.sv */
// self-checking bench of the mode configuration block
`timescale 1ns/10ps

module tmc_top_tb_top;
    localparam logic [15:0] ID = 16'h0a5c; // arbitrary value
    localparam logic [7:0] REV = 8'h01; // arbitrary value
    logic clk = 1'b0; // core clock
    logic rst_n = 1'b0; // reset, active low
    logic host_bus_strap = 1'b1;
    logic host_width_strap = 1'b1;
    logic [1:0] core_clock_rate_select = 2'h1;
    logic read_write_or_serial_phase = 1'b1;
    logic lane0_write_or_serial_clock = 1'b1;
    logic lane1_write_or_serial_in = 1'b1;
    logic lane2_write_or_serial_select = 1'b1;
    logic lane3_write_or_clock_invert = 1'b1;
    logic serial_dout = 1'b0;
    logic [7:0] line_tx_sig = 8'h0;
    logic [7:0] line_tx_multiframe_or_carrier_i = 8'h0;
    logic [7:0] line_rx_signaling_or_request_to_send = 8'h0;
    tmc_pkg::tmc_reg_req_t reg_req;
    tmc_pkg::tmc_host_role_t host_role_o;
    tmc_pkg::tmc_port_cfg_t [7:0] port_cfg_o;
    logic [31:0] reg_rdata, rd_v;
    logic host_d0_o, host_d0_oe, host_ready_n_o, host_ready_oe, high_speed_o, payload_o, rdy_n;
    logic [3:0] par_be_n_o;
    logic [1:0] clk_rate_o;
    logic [7:0] port_active_o, line_tx_multiframe_or_carrier_o, line_tx_multiframe_or_carrier_oe;
    logic [7:0] line_tx_signaling_or_clear_to_send, line_rx_sig_o, line_rts_o, line_mf_sync_o;
    logic [7:0] line_rx_clk_sel_o;
    int num_errors = 0, checked = 0, cycles = 0;

    // ------------
    // clock, instances, checking
    // ------------
    always #10 clk = ~clk;

    tmc_top #(.DEVICE_ID(ID), .REVISION(REV)) i_tmc_top (.clk, .rst_n, .reg_req, .reg_rdata,
        .host_bus_strap, .host_width_strap, .core_clock_rate_select, .read_write_or_serial_phase,
        .lane0_write_or_serial_clock, .lane1_write_or_serial_in, .lane2_write_or_serial_select,
        .lane3_write_or_clock_invert, .serial_dout, .host_d0_o, .host_d0_oe, .host_ready_n_o,
        .host_ready_oe, .host_role_o, .par_be_n_o, .clk_rate_o, .high_speed_o, .payload_o,
        .port_active_o, .port_cfg_o, .line_tx_sig, .line_tx_multiframe_or_carrier_i,
        .line_tx_multiframe_or_carrier_o, .line_tx_multiframe_or_carrier_oe,
        .line_tx_signaling_or_clear_to_send, .line_rx_signaling_or_request_to_send,
        .line_rx_sig_o, .line_rts_o, .line_mf_sync_o, .line_rx_clk_sel_o);
    tmc_host i_tmc_host (.clk, .reg_rdata, .host_ready_n_o, .reg_req);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            print_verdict();
        end
    end

    // straps must already stand; wait past the capture window
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_ident();
        i_tmc_host.rd(6'h04, rd_v, rdy_n);
        chk(rd_v, {ID, 8'h00, REV});
        chk(rdy_n, 1'b0);
        i_tmc_host.rd(6'h08, rd_v, rdy_n);
        chk(rd_v, 32'h12);
        chk(clk_rate_o, 2'h1);
        i_tmc_host.rd(6'h1c, rd_v, rdy_n);
        chk(rd_v, 32'h0);
    endtask

    task automatic t_ports();
        i_tmc_host.wr(6'h20, 32'h09, 4'h0);
        i_tmc_host.wr(6'h28, 32'h26, 4'h0);
        i_tmc_host.wr(6'h2c, 32'h15, 4'h0);
        i_tmc_host.wr(6'h30, 32'h01, 4'h1);
        i_tmc_host.rd(6'h2c, rd_v, rdy_n);
        chk(rd_v, 32'h15);
        i_tmc_host.rd(6'h30, rd_v, rdy_n);
        chk(rd_v, 32'h0);
        chk(port_cfg_o[0], 32'h09);
        chk(port_cfg_o[2], 32'h22);
        chk(port_cfg_o[3], 32'h15);
        chk(line_rx_clk_sel_o, 8'h08);
        chk(line_tx_multiframe_or_carrier_oe, 8'h04);
        chk(line_tx_multiframe_or_carrier_o, 8'h04);
        line_tx_sig <= 8'h08;
        line_tx_multiframe_or_carrier_i <= 8'h08;
        line_rx_signaling_or_request_to_send <= 8'h0c;
        lane0_write_or_serial_clock <= 1'b0;
        repeat (8) @(posedge clk);
        chk(par_be_n_o, 4'he);
        chk(host_role_o, 32'h21);
        chk(line_tx_signaling_or_clear_to_send, 8'h0c);
        chk(line_rts_o, 8'h04);
        chk(line_rx_sig_o, 8'h08);
        chk(line_mf_sync_o, 8'h08);
    endtask

    task automatic t_high_speed();
        i_tmc_host.wr(6'h00, 32'h3, 4'he);
        repeat (3) @(posedge clk);
        chk(high_speed_o, 1'b1);
        chk(payload_o, 1'b1);
        chk(port_active_o, 8'h01);
        chk(port_cfg_o[0], 32'h00);
        i_tmc_host.wr(6'h00, 32'h100, 4'hd);
        i_tmc_host.rd(6'h2c, rd_v, rdy_n);
        chk(rd_v, 32'h0);
        chk(high_speed_o, 1'b0);
        chk(port_active_o, 8'hff);
    endtask

    task automatic t_serial();
        host_bus_strap <= 1'b0;
        host_width_strap <= 1'b0;
        lane2_write_or_serial_select <= 1'b0;
        serial_dout <= 1'b1;
        do_reset();
        repeat (8) @(posedge clk);
        chk(host_role_o, 32'h5a);
        chk(host_d0_o, 1'b1);
        chk(host_d0_oe, 1'b1);
        chk(par_be_n_o, 4'hf);
        i_tmc_host.rd(6'h04, rd_v, rdy_n);
        chk(rdy_n, 1'b1);
        chk(rd_v, {ID, 8'h00, REV});
    endtask

    initial begin
        do_reset();
        t_ident();
        t_ports();
        t_high_speed();
        t_serial();
        print_verdict();
    end
endmodule // tmc_top_tb_top
